/* File: design/dsc_status.sv */
/*
  Status/control flag logic of the background debug unit: tag enable,
  shift-data-valid, single-step, clock-switch select and security
  release, plus debug serial clock source selection.
  Assumes command decode, serial timing and firmware sequencing sit
  outside and deliver one-cycle pulses on clk_sys.
*/
// How it works
// - tag flag set on tag-go command, cleared on active debug entry
// - sixteen cycles after tag write, serial off and tagging on
// - no serial commands serviced while tagging is active
// - data-valid set after firmware read sent or firmware write received
// - data-valid cleared on next command received or debug exit
// - single-step flag set on single-step command, held while repeated
// - single-step flag cleared by a following non-single-step command
// - clock-switch bit written only by hardware debug commands
// - new clock source guaranteed 150 cycles after a switch
// - next command after switch timed on the newly selected clock
// - source: bus if pll 0; alternate if pll 1, sw 0; pll bus if both
// - alternate clock used fully synchronised, no frequency limit
// - write acknowledge of a clock switch already at new rate
// - release flag resets to zero, written only by secure firmware
// - secure table mapped with standard table in special single-chip while release flag zero
// - erase check pass in special single-chip sets release flag, unmaps secure table
// - security off while release flag set; resets secured again
`timescale 1ns/100ps
`default_nettype none
module dsc_status
  import dsc_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  // debug state from the wider unit
  input  wire logic             dbg_enable,
  input  wire logic             dbg_active,
  input  wire logic             dbg_enter,
  input  wire logic             dbg_exit,
  input  wire logic             pll_sel_in,
  input  wire logic             special_single_chip,
  // command events
  input  wire logic             cmd_received,
  input  wire logic             cmd_recognized,
  input  wire logic             cmd_is_step,
  input  wire logic             cmd_tag_go,
  input  wire logic             fw_read_sent,
  input  wire logic             fw_write_rcvd,
  // status byte write path
  input  wire logic             sts_wr,
  input  wire logic             sts_wr_hw,
  input  wire logic             sts_wr_secure,
  input  wire logic [STS_W-1:0] sts_wdata,
  // secure firmware result
  input  wire logic             erase_pass,
  // outputs
  output logic [STS_W-1:0]      sts_rdata,
  output logic                  serial_enable,
  output logic                  tagging_on,
  output logic                  secure_table_map,
  output logic                  security_off,
  output logic [1:0]            clk_src_sel,
  output logic                  clk_switch_busy
);

  // ----------------------------------------------------------------
  // pin-level strap passes a two-stage synchroniser
  // ----------------------------------------------------------------
  logic pll_s1_r, pll_s2_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pll_s1_r <= 1'b0;
      pll_s2_r <= 1'b0;
    end else if (clk_en) begin
      pll_s1_r <= pll_sel_in;
      pll_s2_r <= pll_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // flag state
  // ----------------------------------------------------------------
  logic       tag_r, tag_nxt;
  logic       sdv_r, sdv_nxt;
  logic       step_r, step_nxt;
  logic       clock_switch_select_r, clock_switch_select_nxt;
  logic       rel_r, rel_nxt;
  logic [4:0] tag_cnt_r, tag_cnt_nxt;
  logic       tagon_r, tagon_nxt;
  logic [7:0] sw_cnt_r, sw_cnt_nxt;
  logic       map_r, map_nxt;
  logic [1:0] src_r, src_nxt;
  logic [STS_W-1:0] rd_r, rd_nxt;
  logic       busy_r, busy_nxt;
  logic       sen_r, sen_nxt;

  localparam logic [4:0] TAG_CNT_MAX = 5'(TAG_DELAY_CYC);
  localparam logic [7:0] SW_CNT_MAX  = 8'(CLOCK_SWITCH_SELECT_DELAY_CYC);

  // next-state: sets placed after clears so an event wins over a clear
  always_comb begin
    tag_nxt     = tag_r;
    sdv_nxt     = sdv_r;
    step_nxt    = step_r;
    clock_switch_select_nxt   = clock_switch_select_r;
    rel_nxt     = rel_r;
    tag_cnt_nxt = tag_cnt_r;
    tagon_nxt   = tagon_r;
    sw_cnt_nxt  = sw_cnt_r;
    map_nxt     = map_r;
    src_nxt     = src_r;

    // tag flag and delayed tag switch-over
    if (dbg_enter) begin
      tag_nxt     = 1'b0;
      tagon_nxt   = 1'b0;
      tag_cnt_nxt = 5'h00;
    end
    if (cmd_tag_go && !tagon_r) begin
      tag_nxt     = 1'b1;
      tag_cnt_nxt = TAG_CNT_MAX;
    end else if (tag_cnt_r != 5'h00) begin
      tag_cnt_nxt = tag_cnt_r - 5'h01;
      if (tag_cnt_r == 5'h01) begin
        tagon_nxt = tag_r;
      end
    end

    // shift data valid: clear first so a same-cycle set survives
    if ((cmd_received && !tagon_r) || dbg_exit) begin
      sdv_nxt = 1'b0;
    end
    if (fw_read_sent || fw_write_rcvd) begin
      sdv_nxt = 1'b1;
    end

    // single-step tracking on each recognised command
    if (cmd_recognized && !tagon_r) begin
      step_nxt = cmd_is_step;
    end

    // clock switch only from a hardware debug command
    if (sts_wr && sts_wr_hw && !tagon_r) begin
      clock_switch_select_nxt = sts_wdata[BIT_CLOCK_SWITCH_SELECT];
      if (sts_wdata[BIT_CLOCK_SWITCH_SELECT] != clock_switch_select_r) begin
        sw_cnt_nxt = SW_CNT_MAX;
      end
    end else if (sw_cnt_r != 8'h00) begin
      sw_cnt_nxt = sw_cnt_r - 8'h01;
    end

    // source select takes effect at once so the ack runs at new rate
    if (!pll_s2_r) begin
      src_nxt = DSC_SRC_BUS;
    end else if (!clock_switch_select_nxt) begin
      src_nxt = DSC_SRC_ALT;
    end else begin
      src_nxt = DSC_SRC_PLL;
    end

    // security release from secure firmware in special single-chip
    if (sts_wr && sts_wr_secure && special_single_chip) begin
      rel_nxt = sts_wdata[BIT_RELEASE];
    end
    if (erase_pass && special_single_chip) begin
      rel_nxt = 1'b1;
    end
    // map follows the new flag so unmap lands with the release itself
    map_nxt = special_single_chip && !rel_nxt;

    // registered copies keep every output straight from a flop
    busy_nxt = (sw_cnt_nxt != 8'h00);
    sen_nxt  = !tagon_nxt;
  end

  // status byte image presented to the read commands
  always_comb begin
    rd_nxt              = '0;
    rd_nxt[BIT_ENABLE]  = dbg_enable;
    rd_nxt[BIT_ACTIVE]  = dbg_active;
    rd_nxt[BIT_TAG]     = tag_nxt;
    rd_nxt[BIT_SDV]     = sdv_nxt;
    rd_nxt[BIT_STEP]    = step_nxt;
    rd_nxt[BIT_CLOCK_SWITCH_SELECT]   = clock_switch_select_nxt;
    rd_nxt[BIT_RELEASE] = rel_nxt;
  end

  // register stage; release flag always returns to zero on reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tag_r     <= RST_TAG;
      sdv_r     <= RST_SDV;
      step_r    <= RST_STEP;
      clock_switch_select_r   <= RST_CLOCK_SWITCH_SELECT;
      rel_r     <= RST_RELEASE;
      tag_cnt_r <= 5'h00;
      tagon_r   <= 1'b0;
      sw_cnt_r  <= 8'h00;
      map_r     <= 1'b0;
      src_r     <= DSC_SRC_BUS;
      rd_r      <= '0;
      busy_r    <= 1'b0;
      sen_r     <= 1'b1;
    end else if (clk_en) begin
      tag_r     <= tag_nxt;
      sdv_r     <= sdv_nxt;
      step_r    <= step_nxt;
      clock_switch_select_r   <= clock_switch_select_nxt;
      rel_r     <= rel_nxt;
      tag_cnt_r <= tag_cnt_nxt;
      tagon_r   <= tagon_nxt;
      sw_cnt_r  <= sw_cnt_nxt;
      map_r     <= map_nxt;
      src_r     <= src_nxt;
      rd_r      <= rd_nxt;
      busy_r    <= busy_nxt;
      sen_r     <= sen_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  assign sts_rdata        = rd_r;
  assign tagging_on       = tagon_r;
  assign serial_enable    = sen_r;
  assign secure_table_map = map_r;
  assign security_off     = rel_r;
  assign clk_src_sel      = src_r;
  assign clk_switch_busy  = busy_r;

endmodule : dsc_status
`default_nettype wire

/* File: design/dsc_pkg.sv */
/*
  Constants for the debug status and clock-select block: status byte
  layout, reset values and timing counts.
  Assumes a single system clock at 20 MHz.
*/
package dsc_pkg;

  // ----------------------------------------------------------------
  // status byte field positions
  // ----------------------------------------------------------------
  localparam int unsigned STS_W         = 8;
  localparam int unsigned BIT_ENABLE    = 7;
  localparam int unsigned BIT_ACTIVE    = 6;
  localparam int unsigned BIT_TAG       = 5;
  localparam int unsigned BIT_SDV       = 4;
  localparam int unsigned BIT_STEP      = 3;
  localparam int unsigned BIT_CLOCK_SWITCH_SELECT     = 2;
  localparam int unsigned BIT_RELEASE   = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_TAG     = 1'b0;
  localparam logic RST_SDV     = 1'b0;
  localparam logic RST_STEP    = 1'b0;
  localparam logic RST_CLOCK_SWITCH_SELECT   = 1'b0;
  localparam logic RST_RELEASE = 1'b0;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam int unsigned TAG_DELAY_CYC   = 16;
  localparam int unsigned CLOCK_SWITCH_SELECT_DELAY_CYC = 150;

  // clock source encoding
  typedef enum logic [1:0] {
    DSC_SRC_BUS,
    DSC_SRC_ALT,
    DSC_SRC_PLL
  } dsc_src_t;

endpackage : dsc_pkg

/* File: verif/dsc_status_properties.sv */
/* Checker on the ports of dsc_status.
   Assumes clk_en is held high by the bench. */
`timescale 1ns/100ps
`default_nettype none
module dsc_status_chk (
  input wire logic       clk_sys, rst_b, dbg_enter, dbg_exit, erase_pass,
  input wire logic       cmd_received, cmd_recognized, cmd_is_step,
  input wire logic       cmd_tag_go, fw_read_sent, fw_write_rcvd,
  input wire logic       sts_wr, sts_wr_hw, tagging_on, serial_enable,
  input wire logic       security_off, secure_table_map, clk_switch_busy,
  input wire logic [7:0] sts_wdata, sts_rdata
);
  // ----------------------------------------------------------------
  // flag timing
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // same-cycle entry and tag-go is left open, so it is excluded
  property p_tag_set;
    cmd_tag_go && !tagging_on && !dbg_enter |=> sts_rdata[5]; endproperty
  a_tag_set: assert property (p_tag_set) else $error("tag set");
  property p_tag_clr;
    dbg_enter && !cmd_tag_go |=> !sts_rdata[5] && !tagging_on; endproperty
  a_tag_clr: assert property (p_tag_clr) else $error("tag clr");
  property p_tag_dly; cmd_tag_go && !sts_rdata[5] && !tagging_on
    |-> ##17 tagging_on && !serial_enable; endproperty
  a_tag_dly: assert property (p_tag_dly) else $error("tag dly");
  property p_sdv_set;
    (fw_read_sent || fw_write_rcvd) && !tagging_on |=> sts_rdata[4];
  endproperty
  a_sdv_set: assert property (p_sdv_set) else $error("sdv set");
  property p_sdv_clr; (cmd_received || dbg_exit) && !tagging_on &&
    !fw_read_sent && !fw_write_rcvd |=> !sts_rdata[4]; endproperty
  a_sdv_clr: assert property (p_sdv_clr) else $error("sdv clr");
  property p_step; cmd_recognized && !tagging_on
    |=> sts_rdata[3] == $past(cmd_is_step); endproperty
  a_step: assert property (p_step) else $error("step");
  property p_busy; sts_wr && sts_wr_hw && !tagging_on &&
    sts_wdata[2] != sts_rdata[2] |=> clk_switch_busy ##150 !clk_switch_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy");
  property p_sec;
    erase_pass |=> security_off && sts_rdata[1]; endproperty
  a_sec: assert property (p_sec) else $error("release");
  c_tag: cover property (tagging_on);
  c_busy: cover property ($rose(clk_switch_busy));
  c_sec: cover property (security_off);
endmodule : dsc_status_chk
bind dsc_status dsc_status_chk u_chk (.*);
`default_nettype wire

/* File: verif/dsc_host_model.sv */
/* Debug host model issuing command events.
   Assumes send is called at a falling clk_sys edge. */
`timescale 1ns/100ps
`default_nettype none
module dsc_host_model (
  input  wire logic clk_sys,
  output logic      cmd_received, cmd_recognized, cmd_is_step,
  output logic      cmd_tag_go, fw_read_sent, fw_write_rcvd
);
  // ----------------------------------------------------------------
  // command pulses
  // ----------------------------------------------------------------
  logic [5:0] ev_r = 6'h00;
  // all events timed on the one clock the link uses
  assign {cmd_received, cmd_recognized, cmd_is_step, cmd_tag_go,
          fw_read_sent, fw_write_rcvd} = ev_r;
  // one cycle per event; also sent while tagging, expecting no service
  task automatic send(input logic [5:0] ev);
    ev_r = ev;
    @(negedge clk_sys);
    ev_r = 6'h00;
  endtask : send
endmodule : dsc_host_model
`default_nettype wire

/* File: verif/debug_status_clock_select_tb_top.sv */
/* Testbench for dsc_status.
   Assumes dsc_host_model drives the command events. */
`timescale 1ns/100ps
`default_nettype none
module debug_status_clock_select_tb_top;
  // ----------------------------------------------------------------
  // stimulus and checks
  // ----------------------------------------------------------------
  logic       clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
  logic [5:0] lv = 6'h00;
  logic [3:0] pz = 4'h0;
  logic [7:0] sts_wdata = 8'h00, sts_rdata, o;
  logic [1:0] clk_src_sel;
  logic       dbg_enable, dbg_active, pll_sel_in, special_single_chip;
  logic       sts_wr_hw, sts_wr_secure, dbg_enter, dbg_exit, erase_pass;
  logic       sts_wr, cmd_received, cmd_recognized, cmd_is_step;
  logic       cmd_tag_go, fw_read_sent, fw_write_rcvd, serial_enable;
  logic       tagging_on, secure_table_map, security_off, clk_switch_busy;
  int         errors = 0, checks = 0;
  // packed drives keep each step to one call
  assign {dbg_enable, dbg_active, pll_sel_in, special_single_chip,
          sts_wr_hw, sts_wr_secure} = lv;
  assign {dbg_enter, dbg_exit, erase_pass, sts_wr} = pz;
  // all outputs but sts_rdata in one byte so nothing changes unseen
  assign o = {clk_src_sel, serial_enable, tagging_on, secure_table_map,
              security_off, clk_switch_busy, 1'b0};
  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;
  dsc_status dut (.*);
  dsc_host_model host (.*);
  task automatic chk(input string n, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      $display("unexpected %s exp %h got %h", n, e, s);
      errors++;
    end
  endtask : chk
  task automatic ck(input logic [5:0] l, h, input logic [3:0] d,
                    input logic [7:0] es, eo);
    lv = l;
    pz = d;
    host.send(h);
    pz = 4'h0;
    chk("sts_rdata", es, sts_rdata);
    chk("outputs", eo, o);
  endtask : ck
  task automatic do_reset;
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
  endtask : do_reset
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic t_tag;
    ck(6'h00, 6'h04, 4'h0, 8'h20, 8'h20);
    repeat (15) @(negedge clk_sys);
    chk("outputs", 8'h20, o);
    ck(6'h00, 6'h00, 4'h0, 8'h20, 8'h10);
    ck(6'h00, 6'h18, 4'h0, 8'h20, 8'h10);
    ck(6'h00, 6'h00, 4'h8, 8'h00, 8'h20);
  endtask : t_tag
  task automatic t_flags;
    ck(6'h30, 6'h02, 4'h0, 8'hD0, 8'h20);
    ck(6'h00, 6'h20, 4'h0, 8'h00, 8'h20);
    ck(6'h00, 6'h01, 4'h0, 8'h10, 8'h20);
    ck(6'h00, 6'h21, 4'h0, 8'h10, 8'h20);
    ck(6'h00, 6'h00, 4'h4, 8'h00, 8'h20);
    ck(6'h00, 6'h18, 4'h0, 8'h08, 8'h20);
    ck(6'h00, 6'h18, 4'h0, 8'h08, 8'h20);
    ck(6'h00, 6'h10, 4'h0, 8'h00, 8'h20);
  endtask : t_flags
  task automatic t_clk;
    sts_wdata = 8'h04;
    ck(6'h08, 6'h00, 4'h1, 8'h00, 8'h20);
    repeat (3) @(negedge clk_sys);
    ck(6'h0A, 6'h00, 4'h1, 8'h04, 8'hA2);
    repeat (149) @(negedge clk_sys);
    chk("outputs", 8'hA2, o);
    ck(6'h0A, 6'h00, 4'h0, 8'h04, 8'hA0);
    ck(6'h02, 6'h00, 4'h0, 8'h04, 8'hA0);
    repeat (3) @(negedge clk_sys);
    chk("outputs", 8'h20, o);
    sts_wdata = 8'h00;
    ck(6'h08, 6'h00, 4'h1, 8'h04, 8'h20);
    @(negedge clk_sys);
    ck(6'h0A, 6'h00, 4'h1, 8'h00, 8'h62);
  endtask : t_clk
  task automatic t_sec;
    sts_wdata = 8'h02;
    ck(6'h09, 6'h00, 4'h1, 8'h00, 8'h62);
    ck(6'h0D, 6'h00, 4'h0, 8'h00, 8'h6A);
    ck(6'h0D, 6'h00, 4'h1, 8'h02, 8'h66);
    lv = 6'h04;
    do_reset;
    ck(6'h04, 6'h00, 4'h0, 8'h00, 8'h28);
    ck(6'h04, 6'h00, 4'h2, 8'h02, 8'h24);
  endtask : t_sec
  // main sequence, reset first
  initial begin
    do_reset;
    ck(6'h00, 6'h00, 4'h0, 8'h00, 8'h20);
    t_tag;
    t_flags;
    t_clk;
    t_sec;
    wrap_up;
  end
  // watchdog far beyond the few hundred cycles of the run
  initial begin
    #100us;
    errors++;
    wrap_up;
  end
endmodule : debug_status_clock_select_tb_top
`default_nettype wire
